// file: logic/tcpe_pkg.sv
// Package of offsets, field positions, reset values and counter widths for the channel polarity block.
`default_nettype none
package tcpe_pkg;
	localparam logic [7:0]  CTL_OFFSET     = 8'h20;
	localparam logic [31:0] CTL_RESET      = 32'h0000_0000;
	localparam int          CH_STRIDE      = 4;
	localparam int          EN_POS         = 0;
	localparam int          POL_POS        = 1;
	localparam int          COMP_EN_POS    = 2;
	localparam int          COMP_POL_POS   = 3;
	localparam int          CH3_EN_POS     = 12;
	localparam int          CH3_POL_POS    = 13;
	localparam int          CTL_USED_BITS  = 14;
	localparam logic [1:0]  PROTECTION_LEVEL_LEVEL_2   = 2'h2;
	localparam logic [1:0]  PROTECTION_LEVEL_LEVEL_3   = 2'h3;
	localparam logic [1:0]  DIR_OUTPUT     = 2'h0;
	localparam logic [1:0]  SIZE_HALF      = 2'h1;
	localparam logic [1:0]  SIZE_WORD      = 2'h2;
	localparam int          FILT_CNT_W     = 4;
	localparam int          DIV_CNT_W      = 3;
	localparam int          SAMP_DIV_W     = 6;
	// Filter sampling: code selects divider and required equal samples.
	typedef enum logic [1:0]
	{
		TCPE_F_IDLE   = 2'b00,
		TCPE_F_ARMED  = 2'b01
	} tcpe_filt_state_t;
endpackage : tcpe_pkg
`default_nettype wire

// file: logic/tcpe_input_filter.sv
// Digital input filter: samples at a selected rate and accepts a level after N equal samples.
`default_nettype none
module tcpe_input_filter
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [3:0] filt_code,
	input  wire logic       din,
	output logic            dout
);
	logic [tcpe_pkg::SAMP_DIV_W-1:0] div_r;
	logic [tcpe_pkg::SAMP_DIV_W-1:0] div_nxt;
	logic [tcpe_pkg::FILT_CNT_W-1:0] cnt_r;
	logic [tcpe_pkg::FILT_CNT_W-1:0] cnt_nxt;
	logic                            dout_nxt;
	logic [tcpe_pkg::SAMP_DIV_W-1:0] div_max;
	logic [tcpe_pkg::FILT_CNT_W-1:0] need;

	// Table of sampling divisor minus one and the count of equal samples.
	always_comb
	begin
		case (filt_code)
			4'h1: begin div_max = 6'h00; need = 4'h2; end
			4'h2: begin div_max = 6'h00; need = 4'h4; end
			4'h3: begin div_max = 6'h00; need = 4'h8; end
			4'h4: begin div_max = 6'h01; need = 4'h6; end
			4'h5: begin div_max = 6'h01; need = 4'h8; end
			4'h6: begin div_max = 6'h03; need = 4'h6; end
			4'h7: begin div_max = 6'h03; need = 4'h8; end
			4'h8: begin div_max = 6'h07; need = 4'h6; end
			4'h9: begin div_max = 6'h07; need = 4'h8; end
			4'hA: begin div_max = 6'h0F; need = 4'h5; end
			4'hB: begin div_max = 6'h0F; need = 4'h6; end
			4'hC: begin div_max = 6'h0F; need = 4'h8; end
			4'hD: begin div_max = 6'h1F; need = 4'h5; end
			4'hE: begin div_max = 6'h1F; need = 4'h6; end
			4'hF: begin div_max = 6'h1F; need = 4'h8; end
			default: begin div_max = 6'h00; need = 4'h1; end
		endcase
	end

	// A differing sample counts toward a new level; an equal one resets the run.
	always_comb
	begin
		div_nxt  = div_r;
		cnt_nxt  = cnt_r;
		dout_nxt = dout;
		if (filt_code == 4'h0)
		begin
			dout_nxt = din;
			cnt_nxt  = '0;
			div_nxt  = '0;
		end
		else if (div_r >= div_max)
		begin
			div_nxt = '0;
			if (din == dout)
				cnt_nxt = '0;
			else if (cnt_r + 4'h1 >= need)
			begin
				dout_nxt = din;
				cnt_nxt  = '0;
			end
			else
				cnt_nxt = cnt_r + 4'h1;
		end
		else
			div_nxt = div_r + 6'h01;
	end

	// State registers.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			div_r <= '0;
			cnt_r <= '0;
			dout  <= 1'b0;
		end
		else
		begin
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
			dout  <= dout_nxt;
		end
	end
endmodule // tcpe_input_filter
`default_nettype wire

// file: logic/tcpe_channel_ctl.sv
// Channel enable and polarity control register with capture input conditioning.
`default_nettype none
module tcpe_channel_ctl
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        reg_sel,
	input  wire logic        reg_wr,
	input  wire logic [1:0]  reg_size,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	input  wire logic [1:0]  protection_level,
	input  wire logic [3:0]  direction_select,
	input  wire logic [3:0]  ref_level,
	input  wire logic [3:0]  capture_input,
	input  wire logic [3:0]  ch0_filter_setting,
	input  wire logic [3:0]  ch2_input_filter_setting,
	input  wire logic [1:0]  ch2_capture_edge_divider,
	output logic      [3:0]  channel_out,
	output logic      [3:0]  channel_out_en,
	output logic      [2:0]  comp_out,
	output logic      [2:0]  comp_out_en,
	output logic      [3:0]  active_input,
	output logic             ch0_capture_strobe,
	output logic             ch2_capture_strobe
);
	logic [tcpe_pkg::CTL_USED_BITS-1:0] ctl_r;
	logic [tcpe_pkg::CTL_USED_BITS-1:0] ctl_nxt;
	logic [31:0]                        rdata_nxt;
	logic [tcpe_pkg::DIV_CNT_W-1:0]     div_r;
	logic [tcpe_pkg::DIV_CNT_W-1:0]     div_nxt;
	logic [3:0]                         act_nxt;
	logic [3:0]                         act_r;
	logic [3:0]                         out_nxt;
	logic [3:0]                         oen_nxt;
	logic [2:0]                         cout_nxt;
	logic [2:0]                         coen_nxt;
	logic                               s0_nxt;
	logic                               s2_nxt;
	logic [tcpe_pkg::DIV_CNT_W-1:0]     div_top;
	logic                               ch0_filtered_input;
	logic                               ch2_filtered;
	logic                               protection_level_lock;
	logic                               ch0_channel_on;
	logic                               ch0_polarity;
	logic                               ch0_comp_output_on;
	logic                               ch0_comp_polarity;
	logic                               ch2_channel_on;
	logic                               ch3_channel_on;
	logic                               ch3_polarity;
	logic [3:0]                         ch_pol;
	logic [3:0]                         ch_en;
	logic [2:0]                         ch_cpol;
	logic [2:0]                         ch_cen;
	logic [3:0]                         in_inv;

	assign ch0_channel_on     = ctl_r[tcpe_pkg::EN_POS];
	assign ch0_polarity       = ctl_r[tcpe_pkg::POL_POS];
	assign ch0_comp_output_on = ctl_r[tcpe_pkg::COMP_EN_POS];
	assign ch0_comp_polarity  = ctl_r[tcpe_pkg::COMP_POL_POS];
	assign ch2_channel_on     = ctl_r[2*tcpe_pkg::CH_STRIDE+tcpe_pkg::EN_POS];
	assign ch3_channel_on     = ctl_r[tcpe_pkg::CH3_EN_POS];
	assign ch3_polarity       = ctl_r[tcpe_pkg::CH3_POL_POS];
	assign protection_level_lock = (protection_level == tcpe_pkg::PROTECTION_LEVEL_LEVEL_3) ||
		(protection_level == tcpe_pkg::PROTECTION_LEVEL_LEVEL_2);

	// Per-channel views of the packed fields; channel 3 has no complementary pair.
	assign ch_pol  = {ch3_polarity, ctl_r[2*tcpe_pkg::CH_STRIDE+tcpe_pkg::POL_POS],
		ctl_r[tcpe_pkg::CH_STRIDE+tcpe_pkg::POL_POS], ch0_polarity};
	assign ch_en   = {ch3_channel_on, ch2_channel_on,
		ctl_r[tcpe_pkg::CH_STRIDE+tcpe_pkg::EN_POS], ch0_channel_on};
	assign ch_cpol = {ctl_r[2*tcpe_pkg::CH_STRIDE+tcpe_pkg::COMP_POL_POS],
		ctl_r[tcpe_pkg::CH_STRIDE+tcpe_pkg::COMP_POL_POS], ch0_comp_polarity};
	assign ch_cen  = {ctl_r[2*tcpe_pkg::CH_STRIDE+tcpe_pkg::COMP_EN_POS],
		ctl_r[tcpe_pkg::CH_STRIDE+tcpe_pkg::COMP_EN_POS], ch0_comp_output_on};
	// Polarity 1 inverts an input unless the complementary polarity is also set.
	// That pair is treated as uninverted, since both-edge capture is not offered.
	assign in_inv  = {ch3_polarity, ch_pol[2:0] & ~ch_cpol};

	////////////////////////////////////////////////////////////////////////////
	// Filters for the two capture inputs that feed edge logic.
	tcpe_input_filter u_filt0
	(
		.mclk      (mclk),
		.rst       (rst),
		.filt_code (ch0_filter_setting),
		.din       (capture_input[0]),
		.dout      (ch0_filtered_input)
	);

	tcpe_input_filter u_filt2
	(
		.mclk      (mclk),
		.rst       (rst),
		.filt_code (ch2_input_filter_setting),
		.din       (capture_input[2]),
		.dout      (ch2_filtered)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register write: both sizes land in the low half, where all fields live.
	always_comb
	begin
		ctl_nxt   = ctl_r;
		rdata_nxt = reg_rdata;
		if (reg_sel && (reg_size == tcpe_pkg::SIZE_HALF || reg_size == tcpe_pkg::SIZE_WORD))
		begin
			if (reg_wr)
			begin
				// Bits 31:14 are not stored, so they always read back as zero.
				ctl_nxt = reg_wdata[tcpe_pkg::CTL_USED_BITS-1:0];
				if (protection_level_lock)
				begin
					ctl_nxt[tcpe_pkg::POL_POS]      = ctl_r[tcpe_pkg::POL_POS];
					ctl_nxt[tcpe_pkg::COMP_POL_POS] = ctl_r[tcpe_pkg::COMP_POL_POS];
				end
			end
			else
				rdata_nxt = {18'h0, ctl_r};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel outputs: reference level xor polarity, complementary ones from the inverted reference; output enables need enable and direction output.
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			out_nxt[i] = ref_level[i] ^ ch_pol[i];
			oen_nxt[i] = ch_en[i] && (direction_select[i] == 1'b0);
		end
		for (int j = 0; j < 3; j++)
		begin
			cout_nxt[j] = ~ref_level[j] ^ ch_cpol[j];
			coen_nxt[j] = ch_cen[j] && !direction_select[j];
		end
		// Channels 0 and 2 see their filtered inputs; with filter code 0 glitches pass straight through and can make edges.
		act_nxt[0] = ch0_filtered_input ^ in_inv[0];
		act_nxt[1] = capture_input[1] ^ in_inv[1];
		act_nxt[2] = ch2_filtered ^ in_inv[2];
		act_nxt[3] = capture_input[3] ^ in_inv[3];
	end

	////////////////////////////////////////////////////////////////////////////
	// Active edge detection and channel 2 edge divider.
	always_comb
	begin
		case (ch2_capture_edge_divider)
			2'h0: div_top = 3'h0;
			2'h1: div_top = 3'h1;
			2'h2: div_top = 3'h3;
			default: div_top = 3'h7;
		endcase
		div_nxt = div_r;
		s2_nxt  = 1'b0;
		s0_nxt  = ch0_channel_on && direction_select[0] && act_nxt[0] && !act_r[0];
		if (!ch2_channel_on)
			div_nxt = '0;
		else if (direction_select[2] && act_nxt[2] && !act_r[2])
		begin
			if (div_r >= div_top)
			begin
				div_nxt = '0;
				s2_nxt  = 1'b1;
			end
			else
				div_nxt = div_r + 3'h1;
		end
	end

	// All state and outputs registered here, except the input filter state held in u_filt0 and u_filt2.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ctl_r              <= tcpe_pkg::CTL_RESET[tcpe_pkg::CTL_USED_BITS-1:0];
			reg_rdata          <= '0;
			div_r              <= '0;
			act_r              <= '0;
			active_input       <= '0;
			channel_out        <= '0;
			channel_out_en     <= '0;
			comp_out           <= '0;
			comp_out_en        <= '0;
			ch0_capture_strobe <= 1'b0;
			ch2_capture_strobe <= 1'b0;
		end
		else
		begin
			ctl_r              <= ctl_nxt;
			reg_rdata          <= rdata_nxt;
			div_r              <= div_nxt;
			act_r              <= act_nxt;
			active_input       <= act_nxt;
			channel_out        <= out_nxt;
			channel_out_en     <= oen_nxt;
			comp_out           <= cout_nxt;
			comp_out_en        <= coen_nxt;
			ch0_capture_strobe <= s0_nxt;
			ch2_capture_strobe <= s2_nxt;
		end
	end
endmodule // tcpe_channel_ctl
`default_nettype wire

// file: bench/tcpe_checker.sv
// Checker for the channel control block, driven from a shadow copy of the register.
`default_nettype none
module tcpe_checker
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        reg_sel,
	input wire logic        reg_wr,
	input wire logic [1:0]  reg_size,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic [1:0]  protection_level,
	input wire logic [3:0]  direction_select,
	input wire logic [3:0]  ref_level,
	input wire logic [3:0]  capture_input,
	input wire logic [3:0]  ch0_filter_setting,
	input wire logic [3:0]  channel_out,
	input wire logic [3:0]  channel_out_en,
	input wire logic [2:0]  comp_out,
	input wire logic [2:0]  comp_out_en,
	input wire logic [3:0]  active_input,
	input wire logic        ch0_capture_strobe,
	input wire logic        ch2_capture_strobe
);
	logic [31:0] sh_r;
	logic [31:0] sh_nxt;
	logic        ok_size;
	////////////////////////////////
	// The shadow takes accepted writes; locked polarity bits keep their old value.
	always_comb
	begin
		ok_size = (reg_size == 2'h1) || (reg_size == 2'h2);
		sh_nxt = sh_r;
		if (reg_sel && reg_wr && ok_size)
		begin
			sh_nxt = reg_wdata & 32'h0000_3FFF;
			if (protection_level[1])
			begin
				sh_nxt[1] = sh_r[1];
				sh_nxt[3] = sh_r[3];
			end
		end
	end
	// Shadow register.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sh_r <= 32'h0000_0000;
		else
			sh_r <= sh_nxt;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence rd_s;
		reg_sel && !reg_wr && ok_size;
	endsequence
	// Four idle cycles let any edge already in flight drain first.
	sequence ch2_off_s;
		!sh_r[8] [*4];
	endsequence
	sequence ch0_off_s;
		!sh_r[0] [*4];
	endsequence
	chk_out_polarity: assert property (
		channel_out_en[0] |-> channel_out[0] == ($past(ref_level[0]) ^ $past(sh_r[1])))
		else $error("channel output level wrong");
	chk_comp_polarity: assert property (
		comp_out_en[0] |-> comp_out[0] == (!$past(ref_level[0]) ^ $past(sh_r[3])))
		else $error("complementary output level wrong");
	chk_comp_enable: assert property (
		comp_out_en == ({$past(sh_r[10]), $past(sh_r[6]), $past(sh_r[2])}
		& ~$past(direction_select[2:0])))
		else $error("complementary enable wrong");
	chk_out_enable: assert property (
		channel_out_en == ({$past(sh_r[12]), $past(sh_r[8]), $past(sh_r[4]), $past(sh_r[0])}
		& ~$past(direction_select)))
		else $error("channel enables wrong");
	chk_read_back: assert property (
		rd_s |=> reg_rdata == $past(sh_r))
		else $error("read data differs from register");
	chk_input_pol: assert property (
		$past(direction_select[1]) |-> active_input[1] ==
		($past(capture_input[1]) ^ ($past(sh_r[5]) && !$past(sh_r[7]))))
		else $error("input polarity wrong");
	chk_strobe_pulse: assert property (
		ch2_capture_strobe |=> !ch2_capture_strobe)
		else $error("capture strobe too long");
	chk_ch2_off: assert property (
		ch2_off_s |-> !ch2_capture_strobe)
		else $error("strobe from disabled channel 2");
	chk_ch0_off: assert property (
		ch0_off_s |-> !ch0_capture_strobe)
		else $error("strobe from disabled channel 0");
	chk_ch0_input: assert property (
		$past(ch0_filter_setting, 2) == 4'h0 |->
		active_input[0] == ($past(capture_input[0], 2) ^ ($past(sh_r[1]) && !$past(sh_r[3]))))
		else $error("channel 0 input polarity wrong");
	chk_ch0_strobe: assert property (
		ch0_capture_strobe == ($past(sh_r[0]) && $past(direction_select[0]) &&
		active_input[0] && !$past(active_input[0])))
		else $error("channel 0 capture strobe wrong");
endmodule // tcpe_checker
bind tcpe_channel_ctl tcpe_checker u_chk
(
	.mclk               (mclk),
	.rst                (rst),
	.reg_sel            (reg_sel),
	.reg_wr             (reg_wr),
	.reg_size           (reg_size),
	.reg_wdata          (reg_wdata),
	.reg_rdata          (reg_rdata),
	.protection_level   (protection_level),
	.direction_select   (direction_select),
	.ref_level          (ref_level),
	.capture_input      (capture_input),
	.ch0_filter_setting (ch0_filter_setting),
	.channel_out        (channel_out),
	.channel_out_en     (channel_out_en),
	.comp_out           (comp_out),
	.comp_out_en        (comp_out_en),
	.active_input       (active_input),
	.ch0_capture_strobe (ch0_capture_strobe),
	.ch2_capture_strobe (ch2_capture_strobe)
);
`default_nettype wire

// file: bench/tcpe_partner.sv
// Model of the external capture source: toggles the selected inputs a given number of times.
`default_nettype none
module tcpe_partner
(
	input wire logic       mclk,
	input wire logic       load,
	input wire logic       slow,
	input wire logic [4:0] n_tog,
	input wire logic [3:0] mask,
	output logic     [3:0] capture_input,
	output logic           busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] left_r = 5'h00;
	logic       ph_r   = 1'b0;
	initial capture_input = 4'h0;
	assign busy = (left_r != 5'h00);
	// A slow source spends two cycles per level, so edges come at half the rate.
	always @(posedge mclk)
	begin
		ph_r <= slow && !ph_r;
		if (load)
			left_r <= n_tog;
		else if (busy && !(slow && !ph_r))
		begin
			left_r        <= left_r - 5'h01;
			capture_input <= capture_input ^ mask;
		end
	end
endmodule // tcpe_partner
`default_nettype wire

// file: bench/timer_channel_polarity_enable_tb_top.sv
// Testbench for the channel control block.
`default_nettype none
module timer_channel_polarity_enable_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0;
	logic        rst, reg_sel, reg_wr, load, slow, busy;
	logic        ch0_capture_strobe, ch2_capture_strobe;
	logic [1:0]  reg_size, protection_level, ch2_capture_edge_divider;
	logic [31:0] reg_wdata, reg_rdata, m, p, d;
	logic [3:0]  direction_select, ref_level, capture_input, channel_out, channel_out_en;
	logic [3:0]  ch0_filter_setting, ch2_input_filter_setting, active_input;
	logic [2:0]  comp_out, comp_out_en;
	logic [4:0]  n_tog;
	int          n_errors, n_compared, n_strb, base, i;
	tcpe_channel_ctl dut
	(
		.mclk                     (mclk),
		.rst                      (rst),
		.reg_sel                  (reg_sel),
		.reg_wr                   (reg_wr),
		.reg_size                 (reg_size),
		.reg_wdata                (reg_wdata),
		.reg_rdata                (reg_rdata),
		.protection_level         (protection_level),
		.direction_select         (direction_select),
		.ref_level                (ref_level),
		.capture_input            (capture_input),
		.ch0_filter_setting       (ch0_filter_setting),
		.ch2_input_filter_setting (ch2_input_filter_setting),
		.ch2_capture_edge_divider (ch2_capture_edge_divider),
		.channel_out              (channel_out),
		.channel_out_en           (channel_out_en),
		.comp_out                 (comp_out),
		.comp_out_en              (comp_out_en),
		.active_input             (active_input),
		.ch0_capture_strobe       (ch0_capture_strobe),
		.ch2_capture_strobe       (ch2_capture_strobe)
	);
	// The far side drives channels 0 to 2; capture input 3 is never toggled and stays low.
	tcpe_partner u_far
	(
		.mclk          (mclk),
		.load          (load),
		.slow          (slow),
		.n_tog         (n_tog),
		.mask          (4'h7),
		.capture_input (capture_input),
		.busy          (busy)
	);
	////////////////////////////////
	// Clock, random compare reference and strobe count.
	always #4 mclk = !mclk;
	always @(posedge mclk)
	begin
		ref_level <= 4'($urandom);
		n_strb <= n_strb + int'(ch2_capture_strobe);
	end
	// Expected register after a write; locked polarity bits stay.
	function automatic logic [31:0] nxt(logic [31:0] o, logic [31:0] v, logic [1:0] pl);
		nxt = v & 32'h0000_3FFF;
		if (pl[1])
		begin
			nxt[1] = o[1];
			nxt[3] = o[3];
		end
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One register access; read data has settled when this returns.
	task automatic acc(input logic w, input logic [1:0] sz, input logic [31:0] v);
		reg_sel <= 1'b1;
		reg_wr <= w;
		reg_size <= sz;
		reg_wdata <= v;
		@(posedge mclk);
		reg_sel <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	// Ask the source for n toggles and wait, bounded, until it is done.
	task automatic edges(input logic [4:0] n, input logic s);
		n_tog <= n;
		slow <= s;
		load <= 1'b1;
		@(posedge mclk);
		load <= 1'b0;
		for (int k = 0; k < 100 && (busy || k < 2); k++)
			@(negedge mclk);
		if (busy)
		begin
			n_errors++;
			end_of_test();
		end
		repeat (8) @(posedge mclk);
	endtask
	initial
	begin
		rst = 1'b1;
		{reg_sel, reg_wr, load, slow, reg_size, protection_level} = 8'h00;
		{ch2_capture_edge_divider, reg_wdata, direction_select, n_tog} = 0;
		{ch0_filter_setting, ch2_input_filter_setting, n_strb, m} = 0;
		void'($urandom(46));
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		acc(1'b0, 2'h2, 32'h0);
		chk(reg_rdata, 32'h0, "reset value");
		for (i = 0; i < 24; i++)
		begin
			d = $urandom & 32'h0000_3FFF;
			protection_level <= 2'($urandom);
			direction_select <= 4'($urandom) & 4'hB;
			@(posedge mclk);
			acc(1'b1, (i == 5) ? 2'h0 : 2'h1 + 2'($urandom % 2), d);
			if (reg_size != 2'h0)
				m = nxt(m, d, protection_level);
			acc(1'b0, 2'($urandom % 2) + 2'h1, 32'h0);
			chk(reg_rdata, m, "register");
		end
		$display("test register access done");
		protection_level <= 2'h0;
		direction_select <= 4'h7;
		for (i = 0; i < 4; i++)
		begin
			ch2_capture_edge_divider <= 2'(i);
			p = {22'h0, 1'($urandom), 9'h0};
			acc(1'b1, 2'h2, p);
			acc(1'b1, 2'h2, p | 32'h111);
			base = n_strb;
			edges(5'd16, 1'($urandom));
			chk(32'(n_strb - base), 32'(8 >> i), "capture strobes");
		end
		$display("test edge divider done");
		ch2_capture_edge_divider <= 2'h3;
		base = n_strb;
		edges(5'd10, 1'($urandom));
		acc(1'b1, 2'h2, 32'h011);
		acc(1'b1, 2'h2, 32'h111);
		edges(5'd10, 1'($urandom));
		chk(32'(n_strb - base), 32'h0, "restart count");
		$display("test divider restart done");
		// Code two needs four equal samples, so levels of one or two cycles never pass.
		ch2_capture_edge_divider <= 2'h0;
		ch2_input_filter_setting <= 4'h2;
		base = n_strb;
		edges(5'd10, 1'($urandom));
		chk(32'(n_strb - base), 32'h0, "filtered glitches");
		// Code one needs two equal samples, which a slow source always gives.
		ch2_input_filter_setting <= 4'h1;
		base = n_strb;
		edges(5'd10, 1'b1);
		chk(32'(n_strb - base), 32'h5, "filtered edges");
		$display("test input filter done");
		end_of_test();
	end
endmodule // timer_channel_polarity_enable_tb_top
`default_nettype wire
